// File: wwd_flag_if.sv
// Raw and filtered supervisor flags passed between core and filter
`timescale 1ns/1ps
`include "wwd_params.svh"

interface wwd_flag_if;
    logic [`WWD_N_FLAGS-1:0] raw;
    logic [`WWD_N_FLAGS-1:0] clean;

    modport filt (input raw, output clean);
    modport core (output raw, input clean);
endinterface : wwd_flag_if

// File: wwd_glitch_filter.sv
// Synchroniser and stability filter for the supervisor flags
`timescale 1ns/1ps
`include "wwd_params.svh"

module wwd_glitch_filter
    import wwd_pkg::*;
#(
    parameter int unsigned FILT_CYC = `WWD_FILT_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic rst,
    wwd_flag_if.filt  flags
);

    localparam logic [`WWD_FILT_W-1:0] LAST = `WWD_FILT_W'(FILT_CYC - 1);

    if (FILT_CYC < 1 || FILT_CYC >= 2 ** `WWD_FILT_W)
    begin : g_bad_filt
        $error("FILT_CYC out of range");
    end

    wwd_filt_type r;
    wwd_filt_type next_r;

    always_comb
    begin
        next_r    = r;
        next_r.s1 = flags.raw;
        next_r.s2 = r.s1;
        for (int i = 0; i < `WWD_N_FLAGS; i++)
        begin
            if (r.s2[i] != r.q[i])
            begin
                if (r.cnt[i] == LAST)
                begin
                    next_r.q[i]   = r.s2[i];
                    next_r.cnt[i] = '0;
                end
                else
                begin
                    next_r.cnt[i] = r.cnt[i] + `WWD_FILT_W'(1);
                end
            end
            else
            begin
                next_r.cnt[i] = '0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r <= '{s1: `WWD_FLAG_RST, s2: `WWD_FLAG_RST, cnt: '0, q: `WWD_FLAG_RST};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign flags.clean = r.q;

    for (genvar g = 0; g < `WWD_N_FLAGS; g++)
    begin : g_chk
        flag_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
            $changed(r.q[g]) |-> $past(r.cnt[g]) == LAST && $past(r.s2[g]) == r.q[g])
            else $error("flag changed before it was stable");
    end

endmodule : wwd_glitch_filter

// File: wwd_host_model.sv
// Host model that services the watchdog and pulls up the reset pin
`timescale 1ns/1ps

module wwd_host_model
(
    input  wire logic clk_sys,
    input  wire logic reset_out,
    input  wire logic reset_out_oe,
    output wire logic wd_kick_in,
    output wire logic reset_pin
);
    logic kick_line = 1'b1;

    assign wd_kick_in = kick_line;
    // Open-drain pin reads high through the pull-up when released
    assign reset_pin  = reset_out_oe ? reset_out : 1'b1;

    // One falling edge per call; a long low time models a slow host
    task automatic kick(input int low_cyc);
        @(posedge clk_sys);
        #2;
        kick_line = 1'b0;
        repeat (low_cyc) @(posedge clk_sys);
        #2;
        kick_line = 1'b1;
    endtask : kick
endmodule : wwd_host_model

// File: wwd_params.svh
// Timing, width and field constants of the windowed watchdog reset generator
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

`define WWD_CLK_KHZ        20000
`define WWD_RST_OPEN_US    500
`define WWD_RST_BIAS_MS    200
`define WWD_RST_OPEN_CYC   ((`WWD_RST_OPEN_US * `WWD_CLK_KHZ + 999) / 1000)
`define WWD_RST_BIAS_CYC   (`WWD_RST_BIAS_MS * `WWD_CLK_KHZ)
`define WWD_RST_CAP_TICKS  256
`define WWD_WD_EXPIRY_MS   1600
`define WWD_WD_INT_EXPIRY  8193
`define WWD_WD_EXT_EXPIRY  129
`define WWD_WD_EXT_LOWER   5
`define WWD_WD_INT_DIV     32
`define WWD_WD_TICK_CYC    ((`WWD_WD_EXPIRY_MS * `WWD_CLK_KHZ) / `WWD_WD_INT_EXPIRY)
`define WWD_FILT_NS        1000
`define WWD_FILT_CYC       ((`WWD_FILT_NS * `WWD_CLK_KHZ + 999999) / 1000000)

`define WWD_HOLD_W         32
`define WWD_WD_W           14
`define WWD_TICK_W         16
`define WWD_FILT_W         8
`define WWD_N_FLAGS        4
`define WWD_F_SENSE        0
`define WWD_F_OVER         1
`define WWD_F_UNDER        2
`define WWD_F_UVLO         3
`define WWD_FLAG_RST       4'hF

`endif

// File: wwd_pkg.sv
// Types of the windowed watchdog reset generator
`include "wwd_params.svh"

package wwd_pkg;

    typedef enum logic [1:0] {
        WWD_ST_UVLO = 2'h0,
        WWD_ST_HOLD = 2'h1,
        WWD_ST_RUN  = 2'h2
    } wwd_state_type;

    typedef enum logic [1:0] {
        WWD_RT_OPEN = 2'h0,
        WWD_RT_BIAS = 2'h1,
        WWD_RT_CAP  = 2'h2
    } wwd_rt_mode_type;

    typedef struct packed {
        wwd_state_type           st;
        wwd_rt_mode_type         rt_mode;
        logic                    wt_ext;
        logic                    strap_done;
        logic [`WWD_HOLD_W-1:0]  hold_cnt;
        logic [`WWD_WD_W-1:0]    wd_cnt;
        logic [`WWD_TICK_W-1:0]  tick_cnt;
        logic                    kick_s1;
        logic                    kick_s2;
        logic                    kick_prev;
        logic                    drive;
        logic                    wd_fault;
    } wwd_core_type;

    typedef struct packed {
        logic [`WWD_N_FLAGS-1:0]                  s1;
        logic [`WWD_N_FLAGS-1:0]                  s2;
        logic [`WWD_N_FLAGS-1:0][`WWD_FILT_W-1:0] cnt;
        logic [`WWD_N_FLAGS-1:0]                  q;
    } wwd_filt_type;

endpackage : wwd_pkg

// File: wwd_watchdog_reset.sv
// Supervisor core: reset generation and windowed watchdog
`timescale 1ns/1ps
`include "wwd_params.svh"

module wwd_watchdog_reset
    import wwd_pkg::*;
#(
    parameter int unsigned RST_OPEN_CYC  = `WWD_RST_OPEN_CYC,
    parameter int unsigned RST_BIAS_CYC  = `WWD_RST_BIAS_CYC,
    parameter int unsigned RST_CAP_TICKS = `WWD_RST_CAP_TICKS,
    parameter int unsigned WD_TICK_CYC   = `WWD_WD_TICK_CYC,
    parameter int unsigned FILT_CYC      = `WWD_FILT_CYC
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       reset_sense_low,
    input  wire logic       vout_over,
    input  wire logic       vout_under,
    input  wire logic       vin_uvlo,
    input  wire logic       wd_kick_in,
    input  wire logic [1:0] reset_timing_pin,
    input  wire logic       wd_timing_pin,
    input  wire logic       reset_timing_cap,
    input  wire logic       wd_timing_cap,
    output wire logic       reset_out,
    output wire logic       reset_out_oe,
    output wire logic       wd_fault
);

    localparam logic [`WWD_HOLD_W-1:0] HOLD_OPEN_LAST = `WWD_HOLD_W'(RST_OPEN_CYC - 1);
    localparam logic [`WWD_HOLD_W-1:0] HOLD_BIAS_LAST = `WWD_HOLD_W'(RST_BIAS_CYC - 1);
    localparam logic [`WWD_HOLD_W-1:0] HOLD_CAP_LAST  = `WWD_HOLD_W'(RST_CAP_TICKS - 1);
    localparam logic [`WWD_TICK_W-1:0] TICK_LAST      = `WWD_TICK_W'(WD_TICK_CYC - 1);

    if (RST_OPEN_CYC < 1 || RST_BIAS_CYC < 1 || RST_CAP_TICKS < 1)
    begin : g_bad_hold
        $error("hold counts must be at least one");
    end
    if (WD_TICK_CYC < 1 || WD_TICK_CYC >= 2 ** `WWD_TICK_W)
    begin : g_bad_tick
        $error("WD_TICK_CYC out of range");
    end

    localparam wwd_core_type CORE_RST = '{
        st:         WWD_ST_UVLO,
        rt_mode:    WWD_RT_OPEN,
        wt_ext:     1'b0,
        strap_done: 1'b0,
        hold_cnt:   '0,
        wd_cnt:     '0,
        tick_cnt:   '0,
        kick_s1:    1'b1,
        kick_s2:    1'b1,
        kick_prev:  1'b1,
        drive:      1'b1,
        wd_fault:   1'b0
    };

    // Straps: code 3 on the reset timing strap is treated as open
    function automatic wwd_rt_mode_type rt_strap(input logic [1:0] pin);
        case (pin)
            2'h1:    rt_strap = WWD_RT_BIAS;
            2'h2:    rt_strap = WWD_RT_CAP;
            default: rt_strap = WWD_RT_OPEN;
        endcase
    endfunction : rt_strap

    function automatic logic [`WWD_HOLD_W-1:0] hold_last(input wwd_rt_mode_type m);
        case (m)
            WWD_RT_BIAS: hold_last = HOLD_BIAS_LAST;
            WWD_RT_CAP:  hold_last = HOLD_CAP_LAST;
            default:     hold_last = HOLD_OPEN_LAST;
        endcase
    endfunction : hold_last

    function automatic logic [`WWD_WD_W-1:0] wd_lower(input logic ext);
        wd_lower = ext ? `WWD_WD_W'(`WWD_WD_EXT_LOWER)
                       : `WWD_WD_W'(`WWD_WD_INT_EXPIRY / `WWD_WD_INT_DIV);
    endfunction : wd_lower

    // Upper bound falls one tick before expiry
    function automatic logic [`WWD_WD_W-1:0] wd_upper(input logic ext);
        wd_upper = ext ? `WWD_WD_W'(`WWD_WD_EXT_EXPIRY - 1)
                       : `WWD_WD_W'(`WWD_WD_INT_EXPIRY - 1);
    endfunction : wd_upper

    wwd_flag_if flag_bus ();

    assign flag_bus.raw[`WWD_F_SENSE] = reset_sense_low;
    assign flag_bus.raw[`WWD_F_OVER]  = vout_over;
    assign flag_bus.raw[`WWD_F_UNDER] = vout_under;
    assign flag_bus.raw[`WWD_F_UVLO]  = vin_uvlo;

    wwd_glitch_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_filter (
        .clk_sys (clk_sys),
        .rst     (rst),
        .flags   (flag_bus.filt)
    );

    wwd_core_type r;
    wwd_core_type next_r;

    logic f_uvlo;
    logic f_fault;
    logic hold_inc;
    logic hold_end;
    logic wd_int_tick;
    logic wd_tick;
    logic kick_fall;
    logic kick_early;
    logic wd_last;

    assign f_uvlo      = flag_bus.clean[`WWD_F_UVLO];
    assign f_fault     = flag_bus.clean[`WWD_F_SENSE] | flag_bus.clean[`WWD_F_OVER]
                       | flag_bus.clean[`WWD_F_UNDER];
    assign hold_inc    = (r.rt_mode == WWD_RT_CAP) ? reset_timing_cap : 1'b1;
    assign hold_end    = hold_inc && (r.hold_cnt == hold_last(r.rt_mode));
    assign wd_int_tick = (r.tick_cnt == TICK_LAST);
    assign wd_tick     = r.wt_ext ? wd_timing_cap : wd_int_tick;
    assign kick_fall   = r.kick_prev & ~r.kick_s2;
    assign kick_early  = (r.wd_cnt < wd_lower(r.wt_ext));
    assign wd_last     = (r.wd_cnt == wd_upper(r.wt_ext) - `WWD_WD_W'(1));

    always_comb
    begin
        next_r          = r;
        next_r.wd_fault = 1'b0;
        next_r.kick_s1  = wd_kick_in;
        next_r.kick_s2  = r.kick_s1;
        next_r.kick_prev = r.kick_s2;
        next_r.tick_cnt = wd_int_tick ? '0 : r.tick_cnt + `WWD_TICK_W'(1);
        // Straps are taken once, on the first edge after reset release
        if (!r.strap_done)
        begin
            next_r.rt_mode    = rt_strap(reset_timing_pin);
            next_r.wt_ext     = wd_timing_pin;
            next_r.strap_done = 1'b1;
        end
        unique case (r.st)
            WWD_ST_UVLO:
            begin
                next_r.hold_cnt = '0;
                if (!f_uvlo)
                begin
                    next_r.st = WWD_ST_HOLD;
                end
            end
            WWD_ST_HOLD:
            begin
                if (f_uvlo)
                begin
                    next_r.st       = WWD_ST_UVLO;
                    next_r.hold_cnt = '0;
                end
                else if (f_fault)
                begin
                    next_r.hold_cnt = '0;
                end
                else if (hold_end)
                begin
                    next_r.st       = WWD_ST_RUN;
                    next_r.hold_cnt = '0;
                    next_r.tick_cnt = '0;
                end
                else if (hold_inc)
                begin
                    next_r.hold_cnt = r.hold_cnt + `WWD_HOLD_W'(1);
                end
            end
            WWD_ST_RUN:
            begin
                if (f_uvlo)
                begin
                    next_r.st = WWD_ST_UVLO;
                end
                else if (f_fault)
                begin
                    next_r.st = WWD_ST_HOLD;
                end
                else if (kick_fall)
                begin
                    if (kick_early)
                    begin
                        next_r.st       = WWD_ST_HOLD;
                        next_r.wd_fault = 1'b1;
                    end
                    else
                    begin
                        next_r.wd_cnt = '0;
                    end
                end
                else if (wd_tick)
                begin
                    if (wd_last)
                    begin
                        next_r.st       = WWD_ST_HOLD;
                        next_r.wd_fault = 1'b1;
                    end
                    else
                    begin
                        next_r.wd_cnt = r.wd_cnt + `WWD_WD_W'(1);
                    end
                end
            end
            default:
            begin
                next_r.st = WWD_ST_UVLO;
            end
        endcase
        if (next_r.st != WWD_ST_RUN)
        begin
            next_r.wd_cnt = '0;
        end
        next_r.drive = (next_r.st != WWD_ST_RUN);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r <= CORE_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Open-drain pin: level is always low, enable pulls it down
    assign reset_out    = 1'b0;
    assign reset_out_oe = r.drive;
    assign wd_fault     = r.wd_fault;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    uvlo_hold_a: assert property (f_uvlo |=> reset_out_oe && r.hold_cnt == '0)
        else $error("lockout did not hold reset");

    uvlo_no_count_a: assert property (r.st == WWD_ST_UVLO |-> r.hold_cnt == '0)
        else $error("hold counted during lockout");

    fault_drive_a: assert property (f_fault |=> reset_out_oe)
        else $error("fault did not drive reset");

    hold_restart_a: assert property (r.st == WWD_ST_HOLD && f_fault && !f_uvlo
        |=> r.hold_cnt == '0 && r.st == WWD_ST_HOLD)
        else $error("hold advanced during fault");

    hold_length_a: assert property ($fell(reset_out_oe) |->
        $past(r.hold_cnt) == hold_last(r.rt_mode) && $past(r.st) == WWD_ST_HOLD)
        else $error("reset released before hold period");

    cap_step_a: assert property (r.st == WWD_ST_HOLD && r.rt_mode == WWD_RT_CAP
        && !reset_timing_cap |=> r.hold_cnt == $past(r.hold_cnt) || r.st != WWD_ST_HOLD)
        else $error("capacitor hold counted without tick");

    early_kick_a: assert property (r.st == WWD_ST_RUN && kick_fall && kick_early
        && !f_fault && !f_uvlo |=> reset_out_oe && wd_fault ##1 !wd_fault)
        else $error("early kick not punished");

    late_kick_a: assert property (r.st == WWD_ST_RUN && wd_tick && wd_last && !kick_fall
        && !f_fault && !f_uvlo |=> reset_out_oe && wd_fault && r.wd_cnt == '0)
        else $error("watchdog expiry not punished");

    good_kick_a: assert property (r.st == WWD_ST_RUN && kick_fall && !kick_early
        && !f_fault && !f_uvlo |=> !reset_out_oe && r.wd_cnt == '0 && !wd_fault)
        else $error("valid kick rejected");

    wd_cleared_a: assert property (reset_out_oe |-> r.wd_cnt == '0)
        else $error("watchdog counted during reset");

    wd_restart_a: assert property ($fell(reset_out_oe) |-> r.wd_cnt == '0
        ##1 (r.wd_cnt <= `WWD_WD_W'(1) || reset_out_oe))
        else $error("watchdog did not restart from zero");

    wd_bound_a: assert property (r.wd_cnt < wd_upper(r.wt_ext))
        else $error("watchdog passed upper bound");

    ext_tick_a: assert property (r.st == WWD_ST_RUN && r.wt_ext && !wd_timing_cap
        && !kick_fall |=> r.wd_cnt == $past(r.wd_cnt) || reset_out_oe)
        else $error("external watchdog counted without tick");

    // Entering the run state restarts the divider, so the second step may read zero there
    int_tick_a: assert property (wd_int_tick |=> r.tick_cnt == '0
        ##1 (r.tick_cnt == ((TICK_LAST == '0) ? '0 : `WWD_TICK_W'(1))
             || (r.st == WWD_ST_RUN && $past(r.st) == WWD_ST_HOLD)))
        else $error("internal tick divider wrong");

    // Release only follows a cycle in which every cause had cleared
    release_clear_a: assert property ($fell(reset_out_oe) |->
        !$past(f_fault) && !$past(f_uvlo))
        else $error("reset released while a cause stood");

    run_hold_zero_a: assert property (r.st == WWD_ST_RUN |->
        r.hold_cnt == '0)
        else $error("hold count not cleared in run");

    uvlo_stay_a: assert property (r.st == WWD_ST_UVLO && f_uvlo |=>
        r.st == WWD_ST_UVLO)
        else $error("lockout left while still active");

    fault_rise_a: assert property ($rose(wd_fault) |->
        $rose(reset_out_oe))
        else $error("watchdog flag without reset start");

    strap_hold_a: assert property (r.strap_done |=>
        r.rt_mode == $past(r.rt_mode) && r.wt_ext == $past(r.wt_ext))
        else $error("strap selection changed after sampling");

    release_c: cover property ($fell(reset_out_oe));
    early_c:   cover property (r.st == WWD_ST_RUN && kick_fall && kick_early);
    late_c:    cover property (r.st == WWD_ST_RUN && wd_tick && wd_last);
    good_c:    cover property (r.st == WWD_ST_RUN && kick_fall && !kick_early);
    cap_c:     cover property (r.st == WWD_ST_HOLD && r.rt_mode == WWD_RT_CAP && hold_end);

endmodule : wwd_watchdog_reset

// File: wwd_watchdog_reset_tb.sv
// Self-checking testbench of the windowed watchdog reset generator
`timescale 1ns/1ps

module wwd_watchdog_reset_tb;
    localparam int FILT  = 3;
    localparam int ROPEN = 20;
    localparam int RBIAS = 40;
    localparam int RCAP  = 4;
    localparam int WTICK = 2;
    localparam int TMO   = 40000;

    logic       clk_sys;
    logic       rst;
    logic       reset_sense_low;
    logic       vout_over;
    logic       vout_under;
    logic       vin_uvlo;
    logic [1:0] reset_timing_pin;
    logic       wd_timing_pin;
    logic       reset_timing_cap;
    logic       wd_timing_cap;
    wire logic  wd_kick_in;
    wire logic  reset_out;
    wire logic  reset_out_oe;
    wire logic  wd_fault;
    wire logic  reset_pin;
    int         fail_count;
    int         checked;
    int         cycles;
    int         n;

    wwd_watchdog_reset #(.RST_OPEN_CYC(ROPEN), .RST_BIAS_CYC(RBIAS), .RST_CAP_TICKS(RCAP),
                         .WD_TICK_CYC(WTICK), .FILT_CYC(FILT)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .reset_sense_low(reset_sense_low), .vout_over(vout_over),
        .vout_under(vout_under), .vin_uvlo(vin_uvlo), .wd_kick_in(wd_kick_in),
        .reset_timing_pin(reset_timing_pin), .wd_timing_pin(wd_timing_pin),
        .reset_timing_cap(reset_timing_cap), .wd_timing_cap(wd_timing_cap),
        .reset_out(reset_out), .reset_out_oe(reset_out_oe), .wd_fault(wd_fault));

    wwd_host_model i_host (.clk_sys(clk_sys), .reset_out(reset_out), .reset_out_oe(reset_out_oe),
                           .wd_kick_in(wd_kick_in), .reset_pin(reset_pin));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == TMO)
        begin
            fail_count++;
            $display("unexpected at %0t: run did not finish in time", $time);
            results();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_range(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("unexpected at %0t: %s took %0d, want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chk_range

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask : cyc

    task automatic wait_oe(input logic v, input int maxc);
        n = 0;
        while (reset_out_oe !== v && n < maxc)
        begin
            cyc(1);
            n++;
        end
    endtask : wait_oe

    task automatic set_flag(input int i, input logic v);
        case (i)
            0: reset_sense_low = v;
            1: vout_over = v;
            default: vout_under = v;
        endcase
    endtask : set_flag

    task automatic wd_ticks(input int k);
        repeat (k)
        begin
            wd_timing_cap = 1'b1;
            cyc(1);
            wd_timing_cap = 1'b0;
            cyc(3);
        end
    endtask : wd_ticks

    // Reset with straps, lockout held with a sense fault that must be ignored
    task automatic do_reset(input logic [1:0] rt, input logic wt);
        reset_timing_pin = rt;
        wd_timing_pin    = wt;
        vin_uvlo         = 1'b1;
        rst              = 1'b1;
        cyc(3);
        rst = 1'b0;
        reset_sense_low = 1'b1;
        cyc(20);
        reset_sense_low = 1'b0;
        cyc(20);
        chk_bit(reset_out_oe, 1'b1, "oe in lockout");
        chk_bit(reset_out, 1'b0, "pin level");
    endtask : do_reset

    task automatic power_up(input int hold);
        vin_uvlo = 1'b0;
        wait_oe(1'b0, hold + FILT + 20);
        chk_range(n, hold, hold + FILT + 8, "power-up hold");
        chk_bit(reset_pin, 1'b1, "pin released");
    endtask : power_up

    task automatic t_faults;
        for (int i = 0; i < 3; i++)
        begin
            set_flag(i, 1'b1);
            cyc(FILT - 1);
            set_flag(i, 1'b0);
            cyc(10);
            chk_bit(reset_out_oe, 1'b0, "glitch ignored");
            set_flag(i, 1'b1);
            wait_oe(1'b1, FILT + 10);
            chk_range(n, FILT, FILT + 4, "fault assert");
            chk_bit(wd_fault, 1'b0, "no watchdog flag");
            set_flag(i, 1'b0);
            wait_oe(1'b0, ROPEN + FILT + 20);
            chk_range(n, ROPEN, ROPEN + FILT + 8, "fault release");
        end
        $display("test faults done");
    endtask : t_faults

    task automatic t_window;
        wd_ticks(5);
        i_host.kick(2);
        cyc(8);
        chk_bit(reset_out_oe, 1'b0, "kick at lower bound");
        wd_ticks(4);
        i_host.kick(2);
        wait_oe(1'b1, 12);
        chk_bit(wd_fault, 1'b1, "early kick flag");
        wait_oe(1'b0, ROPEN + 10);
        chk_range(n, ROPEN - 8, ROPEN + 2, "early kick hold");
        wd_ticks(127);
        chk_bit(reset_out_oe, 1'b0, "before upper bound");
        wd_timing_cap = 1'b1;
        cyc(1);
        wd_timing_cap = 1'b0;
        wait_oe(1'b1, 6);
        chk_bit(wd_fault, 1'b1, "expiry flag");
        wd_ticks(3);
        wait_oe(1'b0, ROPEN + 10);
        wd_ticks(127);
        chk_bit(reset_out_oe, 1'b0, "count cleared in hold");
        $display("test window done");
    endtask : t_window

    task automatic t_cap;
        do_reset(2'h2, 1'b1);
        vin_uvlo = 1'b0;
        cyc(ROPEN + FILT + 20);
        chk_bit(reset_out_oe, 1'b1, "cap hold waits ticks");
        for (int i = 0; i < RCAP; i++)
        begin
            chk_bit(reset_out_oe, 1'b1, "cap hold not done");
            reset_timing_cap = 1'b1;
            cyc(1);
            reset_timing_cap = 1'b0;
            cyc(2);
        end
        wait_oe(1'b0, 8);
        chk_range(n, 0, 6, "cap hold release");
        $display("test cap done");
    endtask : t_cap

    // Reset strap code 3 must behave as the open strap
    task automatic t_strap3;
        do_reset(2'h3, 1'b1);
        power_up(ROPEN);
        $display("test strap3 done");
    endtask : t_strap3

    task automatic t_internal;
        do_reset(2'h1, 1'b0);
        power_up(RBIAS);
        cyc(WTICK * 256 + 30);
        i_host.kick(6);
        cyc(6);
        chk_bit(reset_out_oe, 1'b0, "internal kick ok");
        cyc(WTICK * 128);
        i_host.kick(2);
        wait_oe(1'b1, 12);
        chk_bit(wd_fault, 1'b1, "internal early kick");
        wait_oe(1'b0, RBIAS + 10);
        wait_oe(1'b1, WTICK * 8192 + 40);
        chk_range(n, WTICK * 8192 - 8, WTICK * 8192 + 8, "internal expiry");
        $display("test internal done");
    endtask : t_internal

    initial
    begin
        fail_count       = 0;
        checked          = 0;
        cycles           = 0;
        rst              = 1'b1;
        reset_sense_low  = 1'b0;
        vout_over        = 1'b0;
        vout_under       = 1'b0;
        vin_uvlo         = 1'b1;
        reset_timing_pin = 2'h0;
        wd_timing_pin    = 1'b1;
        reset_timing_cap = 1'b0;
        wd_timing_cap    = 1'b0;
        do_reset(2'h0, 1'b1);
        power_up(ROPEN);
        t_faults();
        t_window();
        t_cap();
        t_strap3();
        t_internal();
        results();
    end
endmodule : wwd_watchdog_reset_tb
